// ---- core/vtpg_core.sv ----
// test pattern generator that stands in front of the colour pipeline
`timescale 1ns/1ps

module vtpg_core (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	// configuration control
	input wire logic cfg_apply,
	input wire logic refresh,
	input vtpg_pkg::vtpg_omode_t out_mode,
	// sensor stream
	input wire logic pix_valid,
	input wire logic pix_sof,
	input wire logic pix_sol,
	input wire logic [11:0] pix_data,
	// stream to colour pipeline
	output logic out_valid,
	output logic out_sof,
	output logic out_sol,
	output logic [11:0] out_c0,
	output logic [11:0] out_c1,
	output logic [11:0] out_c2,
	output logic out_ycc,
	// status
	output logic tp_active,
	output logic [7:0] active_kind
);
	import vtpg_pkg::*;

	// ==========================================================
	// reset release
	logic rst_s1_q;
	logic rst_n_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ==========================================================
	// host registers
	logic [7:0] sel_q;
	logic [7:0] kind_q;
	logic [31:0] red_q;
	logic [31:0] green_q;
	logic [31:0] blue_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;

	wire hit_sel = reg_addr == ADDR_CAM_SEL;
	wire hit_kind = reg_addr == ADDR_PAT_KIND;
	wire hit_red = reg_addr == ADDR_RED_LVL;
	wire hit_green = reg_addr == ADDR_GREEN_LVL;
	wire hit_blue = reg_addr == ADDR_BLUE_LVL;

	// unmapped addresses read as zero
	assign rd_mux = hit_sel ? {24'h000000, sel_q} :
		hit_kind ? {24'h000000, kind_q} :
		hit_red ? red_q :
		hit_green ? green_q :
		hit_blue ? blue_q : 32'h0000_0000;

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sel_q <= RST_CAM_SEL;
			kind_q <= RST_PAT_KIND;
			red_q <= RST_LEVEL;
			green_q <= RST_LEVEL;
			blue_q <= RST_LEVEL;
			rdata_q <= 32'h0000_0000;
		end else begin
			if (reg_wr && hit_sel)
				sel_q <= reg_wdata[7:0];
			if (reg_wr && hit_kind)
				kind_q <= reg_wdata[7:0];
			if (reg_wr && hit_red)
				red_q <= reg_wdata;
			if (reg_wr && hit_green)
				green_q <= reg_wdata;
			if (reg_wr && hit_blue)
				blue_q <= reg_wdata;
			if (reg_rd)
				rdata_q <= rd_mux;
		end
	end

	// ==========================================================
	// apply: written selection becomes the live one
	wire is_prog = kind_q == PK_FLAT || kind_q == PK_BARS ||
		kind_q == PK_RAND || kind_q == PK_FADE || kind_q == PK_RAMP;
	wire is_ntsc = kind_q == PK_NTSC7 || kind_q == PK_NTSC8 ||
		kind_q == PK_SMPTE || kind_q == PK_NTSC8B;
	wire is_pal = kind_q == PK_PAL7 || kind_q == PK_PAL8;
	wire code_ok = (out_mode == OM_PROG) ? is_prog :
		(out_mode == OM_NTSC) ? is_ntsc :
		(out_mode == OM_PAL) ? is_pal : 1'b0;
	wire go_sensor = cfg_apply && kind_q == PK_NONE;
	wire go_pattern = cfg_apply && sel_q == SEL_TEST_PATTERN &&
		kind_q != PK_NONE && code_ok;

	logic act_q;
	logic [7:0] akind_q;
	logic [11:0] lvl_r_q;
	logic [11:0] lvl_g_q;
	logic [11:0] lvl_b_q;

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			act_q <= 1'b0;
			akind_q <= PK_NONE;
			lvl_r_q <= 12'h000;
			lvl_g_q <= 12'h000;
			lvl_b_q <= 12'h000;
		end else begin
			if (go_sensor) begin
				act_q <= 1'b0;
				akind_q <= PK_NONE;
			end else if (go_pattern) begin
				act_q <= 1'b1;
				akind_q <= kind_q;
			end
			// levels only move on refresh or a fresh apply
			if (refresh || go_pattern) begin
				lvl_r_q <= red_q[11:0];
				lvl_g_q <= green_q[11:0];
				lvl_b_q <= blue_q[11:0];
			end
		end
	end

	// ==========================================================
	// raster position and bar stepping
	logic [10:0] col_q;
	logic [10:0] row_q;
	logic [10:0] bcnt_q;
	logic [2:0] bidx_q;
	logic [15:0] lfsr_q;

	wire seven = akind_q == PK_NTSC7 || akind_q == PK_PAL7 ||
		akind_q == PK_SMPTE;
	wire prog_bars = akind_q == PK_BARS || akind_q == PK_FADE;
	wire [10:0] bar_w = prog_bars ? BAR_W_PROG :
		seven ? BAR_W_SD7 : BAR_W_SD8;
	wire [2:0] last_bar = seven ? LAST_BAR7 : LAST_BAR8;
	wire [10:0] cur_col = pix_sol ? 11'h000 : col_q;
	wire [10:0] cur_row = pix_sof ? 11'h000 :
		pix_sol ? row_q + 11'h001 : row_q;
	wire [10:0] cur_bcnt = pix_sol ? 11'h000 : bcnt_q;
	wire [2:0] cur_bidx = pix_sol ? 3'h0 : bidx_q;
	wire bar_end = cur_bcnt == bar_w - 11'h001;
	wire [15:0] lfsr_cur = pix_sof ? LFSR_SEED : lfsr_q;
	wire lfsr_fb = lfsr_cur[15] ^ lfsr_cur[13] ^ lfsr_cur[12] ^
		lfsr_cur[10];

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			col_q <= 11'h000;
			row_q <= 11'h000;
			bcnt_q <= 11'h000;
			bidx_q <= 3'h0;
			lfsr_q <= LFSR_SEED;
		end else if (pix_valid) begin
			col_q <= cur_col + 11'h001;
			row_q <= cur_row;
			bcnt_q <= bar_end ? 11'h000 : cur_bcnt + 11'h001;
			if (bar_end && cur_bidx != last_bar)
				bidx_q <= cur_bidx + 3'h1;
			else
				bidx_q <= cur_bidx;
			lfsr_q <= {lfsr_cur[14:0], lfsr_fb};
		end
	end

	// ==========================================================
	// interlaced bar colour choice
	vtpg_color_t sd_color;
	logic [7:0] sd_y;
	logic [7:0] sd_cb;
	logic [7:0] sd_cr;

	wire white75 = akind_q == PK_NTSC8B || akind_q == PK_SMPTE;
	wire smpte_mid = akind_q == PK_SMPTE && cur_row >= SMPTE_ROW_MID &&
		cur_row < SMPTE_ROW_LOW;
	wire smpte_low = akind_q == PK_SMPTE && cur_row >= SMPTE_ROW_LOW;

	always_comb begin
		sd_color = CL_BLACK;
		if (smpte_low) begin
			case (cur_bidx)
				3'h0: sd_color = CL_MINUS_I;
				3'h1: sd_color = CL_WHITE75;
				3'h2: sd_color = CL_PLUS_Q;
				3'h4: sd_color = CL_SUB_BLACK;
				3'h5: sd_color = CL_SUPER_BLACK;
				default: sd_color = CL_BLACK;
			endcase
		end else if (smpte_mid) begin
			case (cur_bidx)
				3'h0: sd_color = CL_BLUE;
				3'h2: sd_color = CL_MAGENTA;
				3'h4: sd_color = CL_CYAN;
				3'h6: sd_color = CL_WHITE75;
				default: sd_color = CL_BLACK;
			endcase
		end else begin
			case (cur_bidx)
				3'h0: sd_color = white75 ? CL_WHITE75 : CL_WHITE100;
				3'h1: sd_color = CL_YELLOW;
				3'h2: sd_color = CL_CYAN;
				3'h3: sd_color = CL_GREEN;
				3'h4: sd_color = CL_MAGENTA;
				3'h5: sd_color = CL_RED;
				3'h6: sd_color = CL_BLUE;
				default: sd_color = CL_BLACK;
			endcase
		end
	end

	vtpg_ycc_lut u_lut (
		.color(sd_color),
		.y(sd_y),
		.cb(sd_cb),
		.cr(sd_cr)
	);

	// ==========================================================
	// progressive pattern values
	wire [2:0] rgb_on = BAR_RGB_SEQ[{1'b0, cur_bidx, 1'b0} +
		{2'b00, cur_bidx} +: 3];
	wire [11:0] row_x2 = {cur_row, 1'b0};
	// fade saturates at mid grey so the bottom rows all meet there
	wire [11:0] fade = (row_x2 > FADE_MAX) ? FADE_MAX : row_x2;
	wire [11:0] ramp = {cur_col, 1'b0};

	function automatic logic [11:0] fade_ch(input logic on,
		input logic [11:0] f);
		fade_ch = on ? FULL_LVL - f : f;
	endfunction

	logic [11:0] c0_d;
	logic [11:0] c1_d;
	logic [11:0] c2_d;
	logic ycc_d;

	always_comb begin
		c0_d = pix_data;
		c1_d = 12'h000;
		c2_d = 12'h000;
		ycc_d = 1'b0;
		if (act_q) begin
			case (akind_q)
				PK_FLAT: begin
					c0_d = lvl_r_q;
					c1_d = lvl_g_q;
					c2_d = lvl_b_q;
				end
				PK_BARS: begin
					c0_d = rgb_on[2] ? FULL_LVL : 12'h000;
					c1_d = rgb_on[1] ? FULL_LVL : 12'h000;
					c2_d = rgb_on[0] ? FULL_LVL : 12'h000;
				end
				PK_RAND: begin
					c0_d = lfsr_cur[11:0];
					c1_d = lfsr_cur[15:4];
					c2_d = {lfsr_cur[7:0], lfsr_cur[15:12]};
				end
				PK_FADE: begin
					c0_d = fade_ch(rgb_on[2], fade);
					c1_d = fade_ch(rgb_on[1], fade);
					c2_d = fade_ch(rgb_on[0], fade);
				end
				PK_RAMP: begin
					c0_d = ramp;
					c1_d = ramp;
					c2_d = ramp;
				end
				default: begin
					c0_d = {4'h0, sd_y};
					c1_d = {4'h0, sd_cb};
					c2_d = {4'h0, sd_cr};
					ycc_d = 1'b1;
				end
			endcase
		end
	end

	// ==========================================================
	// output stage
	logic out_valid_q;
	logic out_sof_q;
	logic out_sol_q;
	logic [11:0] c0_q;
	logic [11:0] c1_q;
	logic [11:0] c2_q;
	logic ycc_q;

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			out_valid_q <= 1'b0;
			out_sof_q <= 1'b0;
			out_sol_q <= 1'b0;
			c0_q <= 12'h000;
			c1_q <= 12'h000;
			c2_q <= 12'h000;
			ycc_q <= 1'b0;
		end else begin
			out_valid_q <= pix_valid;
			out_sof_q <= pix_valid && pix_sof;
			out_sol_q <= pix_valid && pix_sol;
			if (pix_valid) begin
				c0_q <= c0_d;
				c1_q <= c1_d;
				c2_q <= c2_d;
				ycc_q <= ycc_d;
			end
		end
	end

	assign reg_rdata = rdata_q;
	assign out_valid = out_valid_q;
	assign out_sof = out_sof_q;
	assign out_sol = out_sol_q;
	assign out_c0 = c0_q;
	assign out_c1 = c1_q;
	assign out_c2 = c2_q;
	assign out_ycc = ycc_q;
	assign tp_active = act_q;
	assign active_kind = akind_q;

endmodule

// ---- pkg/vtpg_pkg.sv ----
// shared constants and types for the video test pattern generator
package vtpg_pkg;

	// ==========================================================
	// register addresses
	localparam logic [15:0] ADDR_CAM_SEL = 16'hC88C;
	localparam logic [15:0] ADDR_PAT_KIND = 16'hC88F;
	localparam logic [15:0] ADDR_RED_LVL = 16'hC890;
	localparam logic [15:0] ADDR_GREEN_LVL = 16'hC894;
	localparam logic [15:0] ADDR_BLUE_LVL = 16'hC898;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_CAM_SEL = 8'h00;
	localparam logic [7:0] RST_PAT_KIND = 8'h00;
	localparam logic [31:0] RST_LEVEL = 32'h0000_0000;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;

	// ==========================================================
	// operating selector value and pattern kind codes
	localparam logic [7:0] SEL_TEST_PATTERN = 8'h02;
	localparam logic [7:0] PK_NONE = 8'h00;
	localparam logic [7:0] PK_FLAT = 8'h01;
	localparam logic [7:0] PK_BARS = 8'h02;
	localparam logic [7:0] PK_RAND = 8'h05;
	localparam logic [7:0] PK_FADE = 8'h08;
	localparam logic [7:0] PK_RAMP = 8'h09;
	localparam logic [7:0] PK_NTSC7 = 8'h14;
	localparam logic [7:0] PK_NTSC8 = 8'h15;
	localparam logic [7:0] PK_SMPTE = 8'h16;
	localparam logic [7:0] PK_NTSC8B = 8'h17;
	localparam logic [7:0] PK_PAL7 = 8'h1E;
	localparam logic [7:0] PK_PAL8 = 8'h1F;

	// ==========================================================
	// geometry: bar widths in pixels, smpte strip rows per field
	localparam logic [10:0] BAR_W_PROG = 11'h0A0;
	localparam logic [10:0] BAR_W_SD7 = 11'h066;
	localparam logic [10:0] BAR_W_SD8 = 11'h05A;
	localparam logic [2:0] LAST_BAR7 = 3'h6;
	localparam logic [2:0] LAST_BAR8 = 3'h7;
	localparam logic [10:0] SMPTE_ROW_MID = 11'h0A0;
	localparam logic [10:0] SMPTE_ROW_LOW = 11'h0B4;

	// ==========================================================
	// progressive levels; rgb on/off per bar, bar 0 in low bits
	localparam logic [11:0] FULL_LVL = 12'hFFF;
	localparam logic [11:0] FADE_MAX = 12'h7FF;
	localparam logic [23:0] BAR_RGB_SEQ = 24'h0654F7;

	// ==========================================================
	// packed {y, cb, cr} codes
	localparam logic [23:0] YCC_WHITE100 = 24'hEB8080;
	localparam logic [23:0] YCC_WHITE75 = 24'hB48080;
	localparam logic [23:0] YCC_YELLOW = 24'hA22C8E;
	localparam logic [23:0] YCC_CYAN = 24'h839C2C;
	localparam logic [23:0] YCC_GREEN = 24'h70483A;
	localparam logic [23:0] YCC_MAGENTA = 24'h54B8C6;
	localparam logic [23:0] YCC_RED = 24'h4164D4;
	localparam logic [23:0] YCC_BLUE = 24'h23D472;
	localparam logic [23:0] YCC_BLACK = 24'h108080;
	localparam logic [23:0] YCC_MINUS_I = 24'h109C61;
	localparam logic [23:0] YCC_PLUS_Q = 24'h10AB94;
	localparam logic [23:0] YCC_SUB_BLACK = 24'h078080;
	localparam logic [23:0] YCC_SUPER_BLACK = 24'h198080;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		OM_PROG,
		OM_NTSC,
		OM_PAL
	} vtpg_omode_t;

	typedef enum logic [3:0] {
		CL_WHITE100,
		CL_WHITE75,
		CL_YELLOW,
		CL_CYAN,
		CL_GREEN,
		CL_MAGENTA,
		CL_RED,
		CL_BLUE,
		CL_BLACK,
		CL_MINUS_I,
		CL_PLUS_Q,
		CL_SUB_BLACK,
		CL_SUPER_BLACK
	} vtpg_color_t;

endpackage

// ---- core/vtpg_ycc_lut.sv ----
// colour name to luma and chroma code lookup
`timescale 1ns/1ps

module vtpg_ycc_lut (
	// colour in
	input vtpg_pkg::vtpg_color_t color,
	// codes out
	output logic [7:0] y,
	output logic [7:0] cb,
	output logic [7:0] cr
);
	import vtpg_pkg::*;

	logic [23:0] ycc;

	always_comb begin
		case (color)
			CL_WHITE100: ycc = YCC_WHITE100;
			CL_WHITE75: ycc = YCC_WHITE75;
			CL_YELLOW: ycc = YCC_YELLOW;
			CL_CYAN: ycc = YCC_CYAN;
			CL_GREEN: ycc = YCC_GREEN;
			CL_MAGENTA: ycc = YCC_MAGENTA;
			CL_RED: ycc = YCC_RED;
			CL_BLUE: ycc = YCC_BLUE;
			CL_BLACK: ycc = YCC_BLACK;
			CL_MINUS_I: ycc = YCC_MINUS_I;
			CL_PLUS_Q: ycc = YCC_PLUS_Q;
			CL_SUB_BLACK: ycc = YCC_SUB_BLACK;
			CL_SUPER_BLACK: ycc = YCC_SUPER_BLACK;
			default: ycc = YCC_BLACK;
		endcase
	end

	assign y = ycc[23:16];
	assign cb = ycc[15:8];
	assign cr = ycc[7:0];

endmodule

// ---- test/vtpg_core_properties.sv ----
// concurrent checks on the pattern generator ports
`timescale 1ns/1ps

module vtpg_core_props (
	// clock, reset, host side
	input logic ref_clk,
	input logic arst_n,
	input logic reg_wr,
	input logic reg_rd,
	input logic [15:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic [31:0] reg_rdata,
	input logic cfg_apply,
	input vtpg_pkg::vtpg_omode_t out_mode,
	// streams and status
	input logic pix_valid,
	input logic pix_sof,
	input logic pix_sol,
	input logic [11:0] pix_data,
	input logic out_valid,
	input logic out_sof,
	input logic out_sol,
	input logic [11:0] out_c0,
	input logic [11:0] out_c1,
	input logic [11:0] out_c2,
	input logic out_ycc,
	input logic tp_active,
	input logic [7:0] active_kind
);
	import vtpg_pkg::*;
	logic [7:0] sel_q;
	logic [7:0] kind_q;
	wire sel_wr = reg_wr && reg_addr == ADDR_CAM_SEL;
	wire kind_wr = reg_wr && reg_addr == ADDR_PAT_KIND;
	wire sd_kind = active_kind inside {PK_NTSC7, PK_NTSC8, PK_SMPTE,
		PK_NTSC8B, PK_PAL7, PK_PAL8};
	wire bad_kind = kind_q != PK_NONE && (sel_q != SEL_TEST_PATTERN ||
		(out_mode == OM_PROG && kind_q > PK_RAMP));

	// shadows lag writes by one edge, as the apply edge sees them
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_q <= 8'h00;
			kind_q <= 8'h00;
		end else begin
			if (sel_wr)
				sel_q <= reg_wdata[7:0];
			if (kind_wr)
				kind_q <= reg_wdata[7:0];
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	valid_follow_a: assert property (out_valid == $past(pix_valid))
		else $error("out_valid does not follow pix_valid");
	frame_start_a: assert property (pix_valid && pix_sof |=> out_sof && out_sol)
		else $error("frame start not passed on");
	sensor_pass_a: assert property (!tp_active && !cfg_apply && pix_valid
		|=> out_c0 == $past(pix_data) && out_c1 == 12'h000 && !out_ycc)
		else $error("sensor pixel not passed through");
	kind_hold_a: assert property (!cfg_apply |=> $stable(active_kind) && $stable(tp_active))
		else $error("live kind changed without apply");
	leave_test_a: assert property (cfg_apply && kind_q == PK_NONE
		|=> !tp_active && active_kind == PK_NONE)
		else $error("kind zero did not return to sensor");
	enter_flat_a: assert property (cfg_apply && sel_q == SEL_TEST_PATTERN
		&& kind_q == PK_FLAT && out_mode == OM_PROG |=> tp_active && active_kind == PK_FLAT)
		else $error("flat field not entered");
	reserved_kind_a: assert property (cfg_apply && bad_kind |=> $stable(active_kind))
		else $error("reserved kind changed the source");
	ycc_flag_a: assert property (sd_kind && pix_valid |=> out_ycc)
		else $error("bar pattern without luma chroma flag");
	white_bar_a: assert property (active_kind == PK_NTSC7 && pix_valid && pix_sof
		|=> out_c0 == 12'h0EB && out_c1 == 12'h080 && out_c2 == 12'h080)
		else $error("first bar is not white");
	ramp_step_a: assert property (active_kind == PK_RAMP && pix_valid && pix_sol
		##1 pix_valid |=> out_c0 == 12'h002)
		else $error("ramp second pixel wrong");
	read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");

	cover property (cfg_apply && kind_q == PK_SMPTE);
	cover property (tp_active && out_ycc && out_valid);
	cover property (cfg_apply && bad_kind);
endmodule

bind vtpg_core vtpg_core_props i_props (.ref_clk, .arst_n, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .cfg_apply, .out_mode, .pix_valid,
	.pix_sof, .pix_sol, .pix_data, .out_valid, .out_sof, .out_sol, .out_c0,
	.out_c1, .out_c2, .out_ycc, .tp_active, .active_kind);

// ---- test/vtpg_sensor_model.sv ----
// sensor line source feeding the generator's raw input
`timescale 1ns/1ps

module vtpg_sensor_model (
	// control
	input logic ref_clk,
	input logic start,
	input int lines,
	input int len,
	output logic busy,
	// pixel stream
	output logic pix_valid,
	output logic pix_sof,
	output logic pix_sol,
	output logic [11:0] pix_data
);
	initial begin
		busy = 1'b0;
		pix_valid = 1'b0;
		pix_sof = 1'b0;
		pix_sol = 1'b0;
		pix_data = 12'h000;
		forever begin
			@(posedge ref_clk);
			if (start) begin
				busy = 1'b1;
				for (int l = 0; l < lines; l++) begin
					for (int c = 0; c < len; c++) begin
						@(negedge ref_clk);
						pix_valid = 1'b1;
						pix_sof = l == 0 && c == 0;
						pix_sol = c == 0;
						pix_data = c[11:0];
					end
					@(negedge ref_clk);
					pix_valid = 1'b0;
					pix_sof = 1'b0;
					pix_sol = 1'b0;
					// idle data flips so a held value is never mistaken
					pix_data = ~pix_data;
				end
				busy = 1'b0;
			end
		end
	end
endmodule

// ---- test/video_test_pattern_generator_test.sv ----
// self-checking bench for the test pattern generator
`timescale 1ns/1ps

module video_test_pattern_generator_test;
	import vtpg_pkg::*;
	typedef struct packed {
		logic [1:0] m;
		logic [7:0] k;
		logic [10:0] col;
		logic [36:0] px;
	} vtpg_row_t;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic cfg_apply = 1'b0;
	logic refresh = 1'b0;
	logic start = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [31:0] reg_wdata = 32'h0;
	vtpg_omode_t out_mode = OM_PROG;
	logic [31:0] reg_rdata;
	logic pix_valid, pix_sof, pix_sol, busy;
	logic [11:0] pix_data, out_c0, out_c1, out_c2;
	logic out_valid, out_sof, out_sol, out_ycc, tp_active;
	logic [7:0] active_kind;
	logic [36:0] cap [0:1023];
	int idx = 0;
	int cyc = 0;
	int lines = 1;
	int len = 8;
	int failures = 0;
	int comparisons = 0;
	logic [15:0] adr [0:4] = '{ADDR_CAM_SEL, ADDR_PAT_KIND, ADDR_RED_LVL,
		ADDR_GREEN_LVL, ADDR_BLUE_LVL};
	vtpg_row_t rows [0:13] = '{
		'{2'h0, PK_FLAT, 11'h005, 37'h0123456789},
		'{2'h0, PK_BARS, 11'h000, 37'h0FFFFFFFFF},
		'{2'h0, PK_BARS, 11'h0A0, 37'h0FFFFFF000},
		'{2'h0, PK_RAND, 11'h000, 37'h0CE1ACEE1A},
		'{2'h0, PK_FADE, 11'h0AA, 37'h0FFFFFF000},
		'{2'h0, PK_RAMP, 11'h007, 37'h000E00E00E},
		'{2'h1, PK_NTSC7, 11'h000, 37'h10EB080080},
		'{2'h1, PK_NTSC7, 11'h066, 37'h10A202C08E},
		'{2'h1, PK_NTSC7, 11'h2BC, 37'h10230D4072},
		'{2'h1, PK_NTSC8, 11'h276, 37'h1010080080},
		'{2'h1, PK_NTSC8B, 11'h000, 37'h10B4080080},
		'{2'h1, PK_SMPTE, 11'h000, 37'h10B4080080},
		'{2'h2, PK_PAL7, 11'h132, 37'h107004803A},
		'{2'h2, PK_PAL8, 11'h168, 37'h10540B80C6}
	};

	vtpg_core i_dut (.ref_clk, .arst_n, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .cfg_apply, .refresh, .out_mode, .pix_valid,
		.pix_sof, .pix_sol, .pix_data, .out_valid, .out_sof, .out_sol,
		.out_c0, .out_c1, .out_c2, .out_ycc, .tp_active, .active_kind);
	vtpg_sensor_model i_src (.ref_clk, .start, .lines, .len, .busy,
		.pix_valid, .pix_sof, .pix_sol, .pix_data);

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// capture of the last line, indexed by column
	// sampled mid-cycle so registered outputs have long settled
	always @(negedge ref_clk) begin
		cyc++;
		if (out_valid) begin
			idx = out_sol ? 0 : idx + 1;
			cap[idx] = {out_ycc, out_c0, out_c1, out_c2};
		end
		if (cyc == 40000) begin
			failures++;
			final_report();
		end
	end

	// ==========================================================
	// drivers and compares
	task automatic wr(logic [15:0] a, logic [31:0] d);
		@(negedge ref_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(logic [15:0] a);
		@(negedge ref_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic ctl(logic a, logic r);
		@(negedge ref_clk);
		cfg_apply = a;
		refresh = r;
		@(negedge ref_clk);
		cfg_apply = 1'b0;
		refresh = 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic pick(logic [1:0] m, logic [7:0] k);
		@(negedge ref_clk);
		out_mode = vtpg_omode_t'(m);
		wr(ADDR_PAT_KIND, {24'h0, k});
		ctl(1'b1, 1'b0);
	endtask

	task automatic run(int n, int w);
		@(negedge ref_clk);
		lines = n;
		len = w;
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		while (busy)
			@(negedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic chk_px(string n, logic [36:0] e, logic [36:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic chk_st(string n, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task final_report;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		foreach (adr[j]) begin
			rd(adr[j]);
			chk_st("reset value", 32'h0, reg_rdata);
		end
		wr(ADDR_CAM_SEL, 32'hFFFFFF02);
		wr(ADDR_RED_LVL, 32'h000F0123);
		wr(ADDR_GREEN_LVL, 32'h456);
		wr(ADDR_BLUE_LVL, 32'h789);
		rd(ADDR_CAM_SEL);
		chk_st("selector", 32'h02, reg_rdata);
		rd(ADDR_RED_LVL);
		chk_st("red level", 32'h000F0123, reg_rdata);
		rd(16'hC88D);
		chk_st("unmapped", 32'h0, reg_rdata);
		foreach (rows[i]) begin
			pick(rows[i].m, rows[i].k);
			run(1, 720);
			chk_px("pattern", rows[i].px, cap[rows[i].col]);
		end
		pick(2'h0, PK_NTSC7);
		chk_st("reserved", 32'h11F, {23'h0, tp_active, active_kind});
		wr(ADDR_CAM_SEL, 32'h0);
		pick(2'h0, PK_FLAT);
		chk_st("no select", 32'h11F, {23'h0, tp_active, active_kind});
		wr(ADDR_CAM_SEL, 32'h2);
		pick(2'h0, PK_FLAT);
		wr(ADDR_RED_LVL, 32'hABC);
		run(1, 8);
		chk_px("stale level", 37'h0123456789, cap[5]);
		ctl(1'b0, 1'b1);
		run(1, 8);
		chk_px("new level", 37'h0ABC456789, cap[5]);
		pick(2'h1, PK_SMPTE);
		run(171, 4);
		chk_px("reverse strip", 37'h10230D4072, cap[0]);
		run(181, 4);
		chk_px("minus i", 37'h101009C061, cap[0]);
		pick(2'h0, PK_NONE);
		chk_st("sensor", 32'h0, {23'h0, tp_active, active_kind});
		run(1, 8);
		chk_px("sensor pixel", 37'h0003000000, cap[3]);
		// reset between runs with a pattern live must fall back to sensor
		pick(2'h1, PK_NTSC7);
		chk_st("ntsc on", 32'h114, {23'h0, tp_active, active_kind});
		@(negedge ref_clk);
		arst_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk_st("in reset", 32'h0, {23'h0, tp_active, active_kind});
		arst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk_st("after reset", 32'h0, {23'h0, tp_active, active_kind});
		rd(ADDR_CAM_SEL);
		chk_st("selector reset", 32'h0, reg_rdata);
		final_report();
	end
endmodule
